//--- hdl/debug_command_gating.sv
// Debug command parser and permission gate for the on-chip debug unit
`timescale 1ns/1ps
`default_nettype none
module debug_command_gating
  import debug_gating_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        nrst_i,
  input  wire logic        debug_serial_pin_i,
  output var  logic        debug_serial_pin_o,
  output var  logic        debug_serial_pin_oe_o,
  input  wire logic        read_protect_option_i,
  input  wire logic [7:0]  status_i,
  input  wire logic [2:0]  exec_len_i,
  input  wire logic        core_rd_valid_i,
  input  wire logic [7:0]  core_rd_data_i,
  output var  logic        debug_mode_o,
  output var  logic [7:0]  debug_control_o,
  output var  logic [7:0]  core_cmd_o,
  output var  logic [15:0] core_addr_o,
  output var  logic [7:0]  core_byte_o,
  output var  logic        core_wr_o,
  output var  logic        core_rd_o,
  output var  logic        core_go_o
);

  typedef struct packed {
    gate_state_e st;
    logic [7:0]  cmd;
    logic        ok;
    logic        first;
    logic [2:0]  hdr_left;
    logic [31:0] hdr;
    logic [16:0] rem;
    logic [1:0]  idx;
    logic [15:0] addr;
    logic [15:0] caddr;
    logic [7:0]  ctl;
    logic [7:0]  txd;
    logic        txv;
    logic [7:0]  cbyte;
    logic        wr;
    logic        rd;
    logic        go;
  } gate_s;

  gate_s q;
  gate_s d;
  char_if ch ();

  logic cmd_strobe;
  logic cmd_ok;
  logic dbg;

  // Unused and out-of-table codes
  function automatic logic is_reserved(input logic [7:0] c);
    return (c == CMD_RSVD_LOW) || (c == CMD_RSVD_MID) || (c > CMD_EXEC);
  endfunction

  // Permission of a command for the current mode and protection
  function automatic logic cmd_allowed(input logic [7:0] c, input logic dm, input logic rp);
    case (c)
      CMD_READ_REV, CMD_READ_STATUS, CMD_WRITE_CTL, CMD_READ_CTL: return 1'b1;
      CMD_READ_RUNTIME, CMD_READ_CRC, CMD_WRITE_REG:              return dm;
      default:                                                    return dm & ~rp;
    endcase
  endfunction

  // Address and size header length
  function automatic logic [2:0] hdr_len(input logic [7:0] c);
    case (c)
      CMD_WRITE_REG, CMD_READ_REG: return HDR_REG;
      CMD_WRITE_PMEM, CMD_READ_PMEM, CMD_WRITE_DMEM, CMD_READ_DMEM: return HDR_MEM;
      default: return 3'h0;
    endcase
  endfunction

  // Fixed operand bytes
  function automatic logic [16:0] fixed_ops(input logic [7:0] c);
    case (c)
      CMD_WRITE_CTL, CMD_STUFF, CMD_EXEC: return 17'h1;
      CMD_WRITE_PC:                       return 17'h2;
      default:                            return 17'h0;
    endcase
  endfunction

  // Fixed reply bytes
  function automatic logic [16:0] reply_len(input logic [7:0] c);
    case (c)
      CMD_READ_REV, CMD_READ_RUNTIME, CMD_READ_PC, CMD_READ_CRC: return 17'h2;
      CMD_READ_STATUS, CMD_READ_CTL:                             return 17'h1;
      default:                                                   return 17'h0;
    endcase
  endfunction

  // Replies served inside this block
  function automatic logic is_internal(input logic [7:0] c);
    return (c == CMD_READ_REV) || (c == CMD_READ_STATUS) || (c == CMD_READ_CTL);
  endfunction

  // Flash register window and mass erase filter
  function automatic logic reg_write_ok(input logic [15:0] a, input logic [7:0] b);
    return (a >= FLASH_REG_FIRST) && (a <= FLASH_REG_LAST) && ((a != FLASH_CTRL_ADDR) || (b == MASS_ERASE_CMD));
  endfunction

  serial_char_engine u_engine (
    .mclk_i   (mclk_i),
    .nrst_i   (nrst_i),
    .pin_i    (debug_serial_pin_i),
    .pin_o    (debug_serial_pin_o),
    .pin_oe_o (debug_serial_pin_oe_o),
    .ch       (ch.engine)
  );

  assign dbg        = q.ctl[MODE_BIT];
  assign cmd_strobe = ch.rx_valid && (q.st == ST_IDLE);
  assign cmd_ok     = cmd_allowed(ch.rx_data, dbg, read_protect_option_i);

  // Channel and core outputs straight from the state register
  assign ch.tx_valid     = q.txv;
  assign ch.tx_data      = q.txd;
  assign debug_mode_o    = q.ctl[MODE_BIT];
  assign debug_control_o = q.ctl;
  assign core_cmd_o      = q.cmd;
  assign core_addr_o     = q.caddr;
  assign core_byte_o     = q.cbyte;
  assign core_wr_o       = q.wr;
  assign core_rd_o       = q.rd;
  assign core_go_o       = q.go;

  // Command sequencer
  always_comb begin
    logic [16:0] n;
    n     = 17'h0;
    d     = q;
    d.txv = 1'b0;
    d.wr  = 1'b0;
    d.rd  = 1'b0;
    d.go  = 1'b0;
    unique case (q.st)
      ST_IDLE: begin
        if (cmd_strobe && !is_reserved(ch.rx_data)) begin
          d.cmd   = ch.rx_data;
          d.ok    = cmd_ok;
          d.first = 1'b1;
          d.idx   = 2'h0;
          if (hdr_len(ch.rx_data) != 3'h0) begin
            d.st       = ST_HDR;
            d.hdr_left = hdr_len(ch.rx_data);
          end else if (fixed_ops(ch.rx_data) != 17'h0) begin
            d.st  = ST_RXDATA;
            d.rem = fixed_ops(ch.rx_data);
          end else if (reply_len(ch.rx_data) != 17'h0) begin
            d.st  = ST_TXREQ;
            d.rem = reply_len(ch.rx_data);
          end else begin
            d.go = cmd_ok;
          end
        end
      end
      ST_HDR: begin
        if (ch.rx_valid) begin
          d.hdr      = {q.hdr[23:0], ch.rx_data};
          d.hdr_left = q.hdr_left - 3'h1;
          if (q.hdr_left == 3'h1) begin
            if (hdr_len(q.cmd) == HDR_REG) begin
              d.addr = {4'h0, d.hdr[19:8]};
              d.rem  = (d.hdr[7:0] == 8'h00) ? SIZE0_REG : {9'h0, d.hdr[7:0]};
            end else begin
              d.addr = d.hdr[31:16];
              d.rem  = (d.hdr[15:0] == 16'h0) ? SIZE0_MEM : {1'b0, d.hdr[15:0]};
            end
            d.st = (q.cmd == CMD_WRITE_REG || q.cmd == CMD_WRITE_PMEM || q.cmd == CMD_WRITE_DMEM) ?
                   ST_RXDATA : ST_TXREQ;
          end
        end
      end
      ST_RXDATA: begin
        if (ch.rx_valid) begin
          d.first = 1'b0;
          if (q.cmd == CMD_WRITE_CTL) begin
            // mode bit written through the link
            d.ctl = ch.rx_data;
            if (read_protect_option_i) begin
              d.ctl[MODE_BIT] = ch.rx_data[MODE_BIT] | q.ctl[MODE_BIT];
            end
          end else begin
            d.cbyte = ch.rx_data;
            d.caddr = q.addr;
            d.addr  = q.addr + 16'h0001;
            d.wr = q.ok && ((q.cmd != CMD_WRITE_REG) || !read_protect_option_i || reg_write_ok(q.addr, ch.rx_data));
          end
          n = q.rem - 17'h1;
          if (q.cmd == CMD_EXEC && q.first) begin
            n = (exec_len_i == 3'h0) ? 17'h0 : 17'(exec_len_i) - 17'h1;
          end
          d.rem = n;
          if (n == 17'h0) begin
            d.st = ST_IDLE;
            d.go = q.ok && (q.cmd != CMD_WRITE_CTL);
          end
        end
      end
      ST_TXREQ: begin
        if (!q.ok) begin
          d.txd = BLOCKED_BYTE;
          d.st  = ST_SEND;
        end else if (is_internal(q.cmd)) begin
          d.st = ST_SEND;
          if (q.cmd == CMD_READ_REV) begin
            d.txd = (q.idx == 2'h0) ? UNIT_REVISION[15:8] : UNIT_REVISION[7:0];
          end else begin
            d.txd = (q.cmd == CMD_READ_STATUS) ? status_i : q.ctl;
          end
        end else begin
          d.rd = 1'b1;
          d.st = ST_CWAIT;
        end
      end
      ST_CWAIT: begin
        if (core_rd_valid_i) begin
          d.txd = core_rd_data_i;
          d.st  = ST_SEND;
        end
      end
      ST_SEND: begin
        if (!ch.tx_busy) begin
          d.txv = 1'b1;
          d.rem = q.rem - 17'h1;
          d.idx = q.idx + 2'h1;
          d.st  = (q.rem == 17'h1) ? ST_IDLE : ST_TXREQ;
          d.go  = (q.rem == 17'h1) && q.ok && !is_internal(q.cmd);
        end
      end
      default: d.st = ST_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q     <= '0;
      q.st  <= ST_IDLE;
      q.ctl <= CTL_RESET;
    end else begin
      q <= d;
    end
  end

  a_open_cmds: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (cmd_strobe && (ch.rx_data == CMD_READ_REV || ch.rx_data == CMD_READ_STATUS)) ##1 q.st == ST_TXREQ |-> q.ok)
    else $error("Revision or status read refused");
  a_ctl_cmds_open: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (cmd_strobe && (ch.rx_data == CMD_WRITE_CTL || ch.rx_data == CMD_READ_CTL)) |=> q.ok)
    else $error("Control register command refused");
  a_debug_enables: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (cmd_strobe && dbg && !read_protect_option_i && !is_reserved(ch.rx_data)) |=> q.ok)
    else $error("Command refused in debug mode");
  a_rp_pc_reg: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (cmd_strobe && read_protect_option_i &&
     (ch.rx_data == CMD_WRITE_PC || ch.rx_data == CMD_READ_PC || ch.rx_data == CMD_READ_REG)) |=> !q.ok)
    else $error("Protected PC or register command allowed");
  a_rp_memory: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (cmd_strobe && read_protect_option_i && ch.rx_data >= CMD_WRITE_PMEM && ch.rx_data <= CMD_READ_DMEM)
    |=> !q.ok ##1 !core_wr_o[*3])
    else $error("Protected memory command allowed");
  a_rp_instr: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (cmd_strobe && read_protect_option_i && ch.rx_data >= CMD_STEP && ch.rx_data <= CMD_EXEC) |=> !q.ok)
    else $error("Protected instruction command allowed");
  a_mode_sticky: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (read_protect_option_i && debug_mode_o) ##1 read_protect_option_i |-> debug_mode_o)
    else $error("Mode bit cleared under protection");
  a_flash_window: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (core_wr_o && core_cmd_o == CMD_WRITE_REG && $past(read_protect_option_i))
    |-> (core_addr_o >= FLASH_REG_FIRST && core_addr_o <= FLASH_REG_LAST))
    else $error("Non-flash register written under protection");
  a_mass_erase: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (core_wr_o && core_cmd_o == CMD_WRITE_REG && $past(read_protect_option_i) && core_addr_o == FLASH_CTRL_ADDR)
    |-> core_byte_o == MASS_ERASE_CMD)
    else $error("Flash control written with other than mass erase");
  a_reserved_nop: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (cmd_strobe && is_reserved(ch.rx_data)) |=> (q.st == ST_IDLE && !core_go_o && !q.txv))
    else $error("Reserved command acted");
  a_unprotected: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (cmd_strobe && dbg && (ch.rx_data == CMD_READ_RUNTIME || ch.rx_data == CMD_READ_CRC)) |-> cmd_ok)
    else $error("Runtime or checksum read blocked");
  a_mode_entry: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (q.st == ST_RXDATA && q.cmd == CMD_WRITE_CTL && ch.rx_valid && ch.rx_data[MODE_BIT]) |=> debug_mode_o)
    else $error("Mode bit write did not enter debug mode");
  a_blocked_ones: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (ch.tx_valid && !q.ok) |-> ch.tx_data == BLOCKED_BYTE)
    else $error("Blocked read returned data");

endmodule
`default_nettype wire

//--- hdl/debug_gating_pkg.sv
// Constants and types shared by the debug command gating block
package debug_gating_pkg;

  // Command codes
  localparam logic [7:0] CMD_READ_REV     = 8'h00;
  localparam logic [7:0] CMD_READ_STATUS  = 8'h02;
  localparam logic [7:0] CMD_READ_RUNTIME = 8'h03;
  localparam logic [7:0] CMD_WRITE_CTL    = 8'h04;
  localparam logic [7:0] CMD_READ_CTL     = 8'h05;
  localparam logic [7:0] CMD_WRITE_PC     = 8'h06;
  localparam logic [7:0] CMD_READ_PC      = 8'h07;
  localparam logic [7:0] CMD_WRITE_REG    = 8'h08;
  localparam logic [7:0] CMD_READ_REG     = 8'h09;
  localparam logic [7:0] CMD_WRITE_PMEM   = 8'h0a;
  localparam logic [7:0] CMD_READ_PMEM    = 8'h0b;
  localparam logic [7:0] CMD_WRITE_DMEM   = 8'h0c;
  localparam logic [7:0] CMD_READ_DMEM    = 8'h0d;
  localparam logic [7:0] CMD_READ_CRC     = 8'h0e;
  localparam logic [7:0] CMD_RSVD_LOW     = 8'h01;
  localparam logic [7:0] CMD_RSVD_MID     = 8'h0f;
  localparam logic [7:0] CMD_STEP         = 8'h10;
  localparam logic [7:0] CMD_STUFF        = 8'h11;
  localparam logic [7:0] CMD_EXEC         = 8'h12;

  // Debug control register and the reply byte sent for blocked reads
  localparam int         MODE_BIT     = 7;
  localparam logic [7:0] CTL_RESET    = 8'h00;
  localparam logic [7:0] BLOCKED_BYTE = 8'hff;

  // Unit revision, value is arbitrary
  localparam logic [15:0] UNIT_REVISION = 16'h0a5c;

  // Flash control register window and the one value allowed under protection
  localparam logic [15:0] FLASH_REG_FIRST = 16'h0ff8;
  localparam logic [15:0] FLASH_REG_LAST  = 16'h0fff;
  localparam logic [15:0] FLASH_CTRL_ADDR = 16'h0ff8;
  localparam logic [7:0]  MASS_ERASE_CMD  = 8'h63;

  // Header lengths and size-zero meanings
  localparam logic [2:0]  HDR_REG   = 3'h3;
  localparam logic [2:0]  HDR_MEM   = 3'h4;
  localparam logic [16:0] SIZE0_REG = 17'h00100;
  localparam logic [16:0] SIZE0_MEM = 17'h10000;

  // Serial character timing
  localparam int CLK_KHZ    = 20000;
  localparam int BAUD_KBPS  = 2500;
  localparam int BIT_CYCLES = CLK_KHZ / BAUD_KBPS;
  localparam int HALF_BIT   = BIT_CYCLES / 2;
  localparam int CNT_W      = $clog2(BIT_CYCLES) + 1;
  localparam logic [3:0] LAST_BIT = 4'h9;

  typedef enum logic [2:0] {ST_IDLE, ST_HDR, ST_RXDATA, ST_TXREQ, ST_CWAIT, ST_SEND} gate_state_e;

endpackage

//--- hdl/char_if.sv
// Byte channel between the serial character engine and the command gate
`timescale 1ns/1ps
`default_nettype none
interface char_if;
  logic       rx_valid;
  logic [7:0] rx_data;
  logic       tx_valid;
  logic [7:0] tx_data;
  logic       tx_busy;

  modport engine (output rx_valid, output rx_data, output tx_busy, input tx_valid, input tx_data);
  modport ctrl   (input rx_valid, input rx_data, input tx_busy, output tx_valid, output tx_data);
endinterface
`default_nettype wire

//--- hdl/serial_char_engine.sv
// Half-duplex serial character receiver and open-drain transmitter
`timescale 1ns/1ps
`default_nettype none
module serial_char_engine
  import debug_gating_pkg::*;
(
  input  wire logic   mclk_i,
  input  wire logic   nrst_i,
  input  wire logic   pin_i,
  output var  logic   pin_o,
  output var  logic   pin_oe_o,
  char_if.engine      ch
);

  typedef struct packed {
    logic             rx_busy;
    logic [3:0]       rx_bit;
    logic [CNT_W-1:0] rx_cnt;
    logic [7:0]       rx_sh;
    logic             rx_valid;
    logic [7:0]       rx_data;
    logic             tx_busy;
    logic [3:0]       tx_bit;
    logic [CNT_W-1:0] tx_cnt;
    logic [9:0]       tx_sh;
    logic             oe;
    logic             prev;
  } ser_s;

  ser_s q;
  ser_s d;

  // Busy covers the request cycle so the gate never issues twice
  assign ch.tx_busy  = q.tx_busy | ch.tx_valid;
  assign ch.rx_valid = q.rx_valid;
  assign ch.rx_data  = q.rx_data;
  assign pin_oe_o    = q.oe;
  assign pin_o       = 1'b0;

  // Next-state logic for both directions
  always_comb begin
    d          = q;
    d.rx_valid = 1'b0;
    d.prev     = pin_i;
    // start, eight data LSB first, stop
    if (!q.rx_busy) begin
      if (q.prev && !pin_i && !q.tx_busy) begin
        d.rx_busy = 1'b1;
        d.rx_bit  = 4'h0;
        d.rx_cnt  = CNT_W'(HALF_BIT - 1);
      end
    end else if (q.rx_cnt == '0) begin
      d.rx_cnt = CNT_W'(BIT_CYCLES - 1);
      d.rx_bit = q.rx_bit + 4'h1;
      if (q.rx_bit == 4'h0) begin
        d.rx_busy = ~pin_i;                  // Glitch, not a start bit
      end else if (q.rx_bit == LAST_BIT) begin
        d.rx_busy  = 1'b0;
        d.rx_valid = pin_i;                  // Framing error drops the byte
        d.rx_data  = q.rx_sh;
      end else begin
        d.rx_sh = {pin_i, q.rx_sh[7:1]};
      end
    end else begin
      d.rx_cnt = q.rx_cnt - CNT_W'(1);
    end
    if (!q.tx_busy) begin
      if (ch.tx_valid) begin
        d.tx_busy = 1'b1;
        d.tx_sh   = {1'b1, ch.tx_data, 1'b0};
        d.tx_bit  = 4'h0;
        d.tx_cnt  = CNT_W'(BIT_CYCLES - 1);
        d.oe      = 1'b1;
      end
    end else if (q.tx_cnt == '0) begin
      d.tx_cnt = CNT_W'(BIT_CYCLES - 1);
      if (q.tx_bit == LAST_BIT) begin
        d.tx_busy = 1'b0;
        d.oe      = 1'b0;
      end else begin
        d.tx_bit = q.tx_bit + 4'h1;
        d.tx_sh  = {1'b1, q.tx_sh[9:1]};
        d.oe     = ~q.tx_sh[1];
      end
    end else begin
      d.tx_cnt = q.tx_cnt - CNT_W'(1);
    end
  end

  // State register
  always_ff @(posedge mclk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      q      <= '0;
      q.prev <= 1'b1;
    end else begin
      q <= d;
    end
  end

  a_stop_released: assert property (@(posedge mclk_i) disable iff (!nrst_i)
    (q.tx_busy && q.tx_bit == LAST_BIT) |-> !q.oe)
    else $error("Stop bit driven low");

endmodule
`default_nettype wire

//--- test/debug_host_model.sv
// Host side of the single-wire debug link: byte sender and reply receiver
`timescale 1ns/1ps
`default_nettype none
module debug_host_model
  import debug_gating_pkg::*;
(
  input  wire logic mclk_i,
  input  wire logic line_i,
  output var  logic pull_o
);
  initial pull_o = 1'b0;

  // one command or operand byte per call
  // start bit, eight data bits LSB first, stop bit
  task automatic send(input logic [7:0] b);
    repeat (12) @(posedge mclk_i);
    pull_o <= 1'b1;
    repeat (BIT_CYCLES) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      pull_o <= ~b[i];
      repeat (BIT_CYCLES) @(posedge mclk_i);
    end
    pull_o <= 1'b0;
    repeat (HALF_BIT) @(posedge mclk_i);
  endtask

  // Bounded wait for a start bit, then mid-bit samples; ok low on timeout or low stop
  // reply framing checked on receive
  task automatic recv(output logic [7:0] b, output logic ok);
    int n;
    n = 0;
    ok = 1'b1;
    b = 8'h00;
    while (line_i !== 1'b0 && n < 600) begin
      @(posedge mclk_i);
      n++;
    end
    if (n >= 600) ok = 1'b0;
    repeat (HALF_BIT) @(posedge mclk_i);
    for (int i = 0; i < 8; i++) begin
      repeat (BIT_CYCLES) @(posedge mclk_i);
      b[i] = line_i;
    end
    repeat (BIT_CYCLES) @(posedge mclk_i);
    if (line_i !== 1'b1) ok = 1'b0;
  endtask
endmodule
`default_nettype wire

//--- test/test_debug_command_gating.sv
// Self-checking bench for the debug command gate
`timescale 1ns/1ps
`default_nettype none
module test_debug_command_gating
  import debug_gating_pkg::*;
;
  logic        mclk_i, nrst_i, read_protect_option_i, core_rd_valid_i, pull, line;
  logic [7:0]  status_i, core_rd_data_i, debug_control_o, core_cmd_o, core_byte_o;
  logic [2:0]  exec_len_i;
  logic [15:0] core_addr_o;
  logic        pin_o, pin_oe_o, debug_mode_o, core_wr_o, core_rd_o, core_go_o;
  int          fails = 0, comparisons = 0, n_wr = 0, n_rd = 0, n_go = 0, cycles = 0;

  // Open-drain wire with pull-up
  assign line = ~(pull | (pin_oe_o & ~pin_o));

  debug_host_model host (.mclk_i(mclk_i), .line_i(line), .pull_o(pull));

  debug_command_gating DUT (
    .mclk_i(mclk_i), .nrst_i(nrst_i), .debug_serial_pin_i(line), .debug_serial_pin_o(pin_o),
    .debug_serial_pin_oe_o(pin_oe_o), .read_protect_option_i(read_protect_option_i),
    .status_i(status_i), .exec_len_i(exec_len_i), .core_rd_valid_i(core_rd_valid_i),
    .core_rd_data_i(core_rd_data_i), .debug_mode_o(debug_mode_o), .debug_control_o(debug_control_o),
    .core_cmd_o(core_cmd_o), .core_addr_o(core_addr_o), .core_byte_o(core_byte_o),
    .core_wr_o(core_wr_o), .core_rd_o(core_rd_o), .core_go_o(core_go_o));

  initial begin
    mclk_i = 1'b0;
    forever #25 mclk_i = ~mclk_i;
  end

  // Core stand-in answers each read request one cycle later; pulses are counted
  always @(posedge mclk_i) begin
    cycles <= cycles + 1;
    if (core_wr_o === 1'b1) n_wr <= n_wr + 1;
    if (core_rd_o === 1'b1) n_rd <= n_rd + 1;
    if (core_go_o === 1'b1) n_go <= n_go + 1;
    core_rd_valid_i <= core_rd_o;
    core_rd_data_i  <= 8'h5a;
  end

  task automatic end_sim;
    $display("comparisons=%0d fails=%0d", comparisons, fails);
    if (fails == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  task automatic check8(input logic [7:0] got, input logic [7:0] exp);
    comparisons++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic [7:0] q[$]);
    foreach (q[i]) host.send(q[i]);
  endtask

  task automatic reply(input logic [7:0] exp);
    logic [7:0] b;
    logic       ok;
    host.recv(b, ok);
    check8({7'h0, ok}, 8'h01);
    check8(b, exp);
  endtask

  task automatic settle;
    repeat (20) @(posedge mclk_i);
  endtask

  task automatic quiet;
    logic seen;
    seen = 1'b0;
    repeat (150) begin
      @(posedge mclk_i);
      if (line === 1'b0) seen = 1'b1;
    end
    check8({7'h0, seen}, 8'h00);
  endtask

  // Normal operation: only the small command set is served; blocked reads get BLOCKED_BYTE
  task automatic s_normal;
    int r0, g0;
    r0 = n_rd;
    g0 = n_go;
    cmd('{CMD_READ_REV});
    reply(UNIT_REVISION[15:8]);
    reply(UNIT_REVISION[7:0]);
    cmd('{CMD_READ_STATUS});
    reply(8'h96);
    cmd('{CMD_READ_CTL});
    reply(CTL_RESET);
    cmd('{CMD_READ_REG, 8'h00, 8'h10, 8'h02});
    reply(BLOCKED_BYTE);
    reply(BLOCKED_BYTE);
    cmd('{CMD_STEP});
    cmd('{CMD_RSVD_MID});
    quiet;
    check8(8'(n_rd - r0), 8'h00);
    check8(8'(n_go - g0), 8'h00);
  endtask

  // Entering debug mode opens the full command set
  task automatic s_enter;
    int r0, g0;
    cmd('{CMD_WRITE_CTL, 8'h80});
    settle;
    check8({7'h0, debug_mode_o}, 8'h01);
    check8(debug_control_o, 8'h80);
    cmd('{CMD_READ_CTL});
    reply(8'h80);
    r0 = n_rd;
    g0 = n_go;
    cmd('{CMD_READ_PC});
    reply(8'h5a);
    reply(8'h5a);
    cmd('{CMD_STEP});
    // Two-byte instruction exercises the length input
    @(posedge mclk_i);
    exec_len_i <= 3'h2;
    cmd('{CMD_EXEC, 8'h00, 8'h00});
    @(posedge mclk_i);
    exec_len_i <= 3'h1;
    settle;
    check8(core_cmd_o, CMD_EXEC);
    check8(8'(n_rd - r0), 8'h02);
    check8(8'(n_go - g0), 8'h03);
    check8({7'h0, pin_o}, 8'h00);
  endtask

  // Protection blocks the code-revealing commands and filters writes
  task automatic s_protect;
    int r0, g0, w0;
    @(posedge mclk_i);
    read_protect_option_i <= 1'b1;
    r0 = n_rd;
    g0 = n_go;
    w0 = n_wr;
    cmd('{CMD_STEP});
    cmd('{CMD_STUFF, 8'h00});
    cmd('{CMD_EXEC, 8'h00});
    cmd('{CMD_WRITE_PC, 8'h12, 8'h34});
    cmd('{CMD_READ_PC});
    reply(BLOCKED_BYTE);
    reply(BLOCKED_BYTE);
    cmd('{CMD_READ_PMEM, 8'h00, 8'h00, 8'h00, 8'h01});
    reply(BLOCKED_BYTE);
    cmd('{CMD_READ_DMEM, 8'h00, 8'h00, 8'h00, 8'h01});
    reply(BLOCKED_BYTE);
    cmd('{CMD_WRITE_DMEM, 8'h00, 8'h00, 8'h00, 8'h01, 8'h77});
    settle;
    check8(8'(n_go - g0), 8'h00);
    check8(8'(n_rd - r0), 8'h00);
    check8(8'(n_wr - w0), 8'h00);
    cmd('{CMD_WRITE_REG, 8'h00, 8'h10, 8'h01, 8'h55});
    settle;
    check8(8'(n_wr - w0), 8'h00);
    cmd('{CMD_WRITE_REG, 8'h0f, 8'hf8, 8'h01, 8'h12});
    settle;
    check8(8'(n_wr - w0), 8'h00);
    cmd('{CMD_WRITE_REG, 8'h0f, 8'hf8, 8'h01, MASS_ERASE_CMD});
    settle;
    check8(8'(n_wr - w0), 8'h01);
    check8(core_byte_o, MASS_ERASE_CMD);
    check8(core_addr_o[15:8], FLASH_CTRL_ADDR[15:8]);
    check8(core_addr_o[7:0], FLASH_CTRL_ADDR[7:0]);
    check8(core_cmd_o, CMD_WRITE_REG);
    cmd('{CMD_READ_RUNTIME});
    reply(8'h5a);
    reply(8'h5a);
    cmd('{CMD_WRITE_CTL, 8'h00});
    settle;
    check8({7'h0, debug_mode_o}, 8'h01);
  endtask

  // Without protection the mode bit clears again
  task automatic s_clear;
    @(posedge mclk_i);
    read_protect_option_i <= 1'b0;
    cmd('{CMD_WRITE_CTL, 8'h00});
    settle;
    check8({7'h0, debug_mode_o}, 8'h00);
  endtask

  // Cuts a hang short
  initial begin
    wait (cycles >= 40000);
    fails++;
    end_sim;
  end

  initial begin
    nrst_i = 1'b0;
    read_protect_option_i = 1'b0;
    status_i = 8'h96;
    exec_len_i = 3'h1;
    core_rd_valid_i = 1'b0;
    core_rd_data_i = 8'h00;
    repeat (3) @(posedge mclk_i);
    nrst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    s_normal;
    s_enter;
    s_protect;
    s_clear;
    end_sim;
  end
endmodule
`default_nettype wire
